// File: tb/apb_host_model.sv
// Host model that issues one APB command at a time.
`timescale 1ns/1ns
`default_nettype none
module apb_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int gap = 0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  // A command waits for the last answer; released buses are scrambled.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    repeat (gap) @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    ok = n < 20;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // apb_host_model
`default_nettype wire

// File: tb/camera_cfg_monitor.sv
// Concurrent checks on the ports of the camera configuration block.
`timescale 1ns/1ns
`default_nettype none
module camera_cfg_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ffc_generate,
  input wire logic line_oe_n,
  input wire logic ten_bit_depth
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic wr_ok = pready && pwrite && !pslverr;
  a_ready_next: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_depth_out: assert property (wr_ok && paddr == 8'h00 |->
    ##2 ten_bit_depth == ($past(pwdata, 2) == 32'hA))
    else $error("depth output wrong");
  a_depth_bad: assert property (setup && pwrite && paddr == 8'h00 &&
    pwdata != 32'h8 && pwdata != 32'hA |=> pslverr)
    else $error("bad depth accepted");
  a_unmapped_err: assert property (setup && paddr > 8'h44 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access answered");
  a_ro_wo_err: assert property (setup && (pwrite ? paddr == 8'h40 : paddr == 8'h1C) |=> pslverr)
    else $error("wrong direction accepted");
  a_ffc_cause: assert property (wr_ok && paddr == 8'h1C && pwdata[0] |-> ##[1:2] ffc_generate)
    else $error("generate pulse missing");
  a_ffc_single: assert property ($rose(ffc_generate) |=> !ffc_generate)
    else $error("generate pulse too long");
  a_line_input: assert property (wr_ok && paddr == 8'h20 && pwdata == 32'h0 |-> ##2 line_oe_n)
    else $error("line driven in input mode");
endmodule // camera_cfg_monitor
bind camera_cfg camera_cfg_monitor u_camera_cfg_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .ffc_generate, .line_oe_n, .ten_bit_depth);
`default_nettype wire

// File: tb/tb_camera_cfg.sv
// Self-checking testbench for the camera configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb_camera_cfg;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic frame_active = 1'b0;
  logic exposure_active = 1'b0;
  logic line_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, ok;
  logic line_out, line_oe_n, ten_bit_depth, slow_pixel_clock, defect_correct_en, flip_en;
  logic ffc_generate, ffc_save, ffc_load, free_run_trigger, pulse_timer_output;
  logic [3:0] tap_count;
  logic [1:0] ffc_location;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int num_errors = 0;
  int checks_done = 0;
  int tap [4] = '{2, 4, 8, 10};
  int src [5] = '{0, 4, 6, 10, 18};
  int bk [10] = '{0, 2, 3, 6, 8, 11, 12, 13, 14, 1};
  logic [31:0] bv [10] = '{32'h9, 32'h3, 32'h2, 32'h4, 32'h5, 32'hA, 32'h0, 32'h0393_8701, 32'h4, 32'h0};
  logic [7:0] ad [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
    8'h34, 8'h38, 8'h3C, 8'h44};
  logic [31:0] m [16] = '{32'h8, 32'h3E8, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
  always #10 pclk = ~pclk;
  apb_host_model u_apb_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  camera_cfg u_camera_cfg (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_active, .exposure_active, .line_in, .line_out, .line_oe_n, .ten_bit_depth, .tap_count,
    .slow_pixel_clock, .defect_correct_en, .flip_en, .ffc_generate, .ffc_save, .ffc_load, .ffc_location,
    .free_run_trigger, .pulse_timer_output);
  function automatic logic [31:0] legal(input int k, input int unsigned r);
    case (ad[k])
      8'h00: return r % 2 ? 32'hA : 32'h8;
      8'h04, 8'h34: return 32'(1 + r % 3);
      8'h38: return 32'(r % 3);
      8'h08: return 32'(tap[r % 4]);
      8'h24: return 32'(src[r % 5]);
      8'h30: return 32'(src[r % 3]);
      8'h18, 8'h3C: return 32'(r % 4);
      default: return 32'(r % 2);
    endcase
  endfunction
  function automatic logic [9:0] outs();
    return {m[0] == 32'hA, m[2][3:0], m[3][0], m[4][0], m[5][0], m[6][1:0]};
  endfunction
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d errors", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    u_apb_host_model.xfer(w, a, d, rd, er, ok);
    if (ok !== 1'b1)
    begin
      num_errors++;
      tally_and_finish();
    end
    chk(32'(er), 32'(e));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    go(1'b0, a, 32'h0, e);
    chk(rd, exp);
  endtask
  initial
  begin
    int unsigned r;
    int k, n, c, i;
    r = $urandom(5);
    cyc(3);
    presetn <= 1'b1;
    cyc(2);
    chk({27'h0, line_oe_n, tap_count}, 32'h12);
    for (k = 0; k < 16; k++)
      rc(ad[k], m[k], 1'b0);
    rc(8'h40, 32'h0000_0008, 1'b0);
    $display("test reset done");
    for (n = 0; n < 120; n++)
    begin
      k = n < 80 ? n % 16 : $urandom % 16;
      r = n < 80 ? n / 16 : $urandom;
      u_apb_host_model.gap = $urandom % 3;
      {frame_active, exposure_active, line_in} <= 3'($urandom);
      m[k] = legal(k, r);
      go(1'b1, ad[k], m[k], 1'b0);
      rc(ad[k], m[k], 1'b0);
      cyc(2);
      chk(32'(outs()),
        32'({ten_bit_depth, tap_count, slow_pixel_clock, defect_correct_en, flip_en, ffc_location}));
    end
    $display("test settings done");
    for (n = 0; n < 10; n++)
    begin
      go(1'b1, ad[bk[n]], bv[n], 1'b1);
      rc(ad[bk[n]], m[bk[n]], 1'b0);
    end
    go(1'b1, 8'h40, 32'h0, 1'b1);
    rc(8'h48, 32'h0, 1'b1);
    go(1'b0, 8'h1C, 32'h0, 1'b1);
    go(1'b1, 8'h34, 32'h0393_8700, 1'b0);
    rc(8'h34, 32'h0393_8700, 1'b0);
    $display("test refusals done");
    go(1'b1, 8'h1C, 32'h7, 1'b0);
    c = 0;
    repeat (4)
    begin
      c += ffc_generate + 4 * ffc_save + 16 * ffc_load;
      @(posedge pclk);
    end
    chk(32'(c), 32'h15);
    $display("test flat field done");
    go(1'b1, 8'h30, 32'h4, 1'b0);
    go(1'b1, 8'h38, 32'h1, 1'b0);
    go(1'b1, 8'h34, 32'h2, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      go(1'b1, 8'h3C, 32'(i), 1'b0);
      frame_active <= i % 2 == 0;
      cyc(300);
      frame_active <= i % 2 != 0;
      n = 0;
      while (pulse_timer_output !== 1'b1 && n < 300)
      begin
        n++;
        @(posedge pclk);
      end
      c = 0;
      while (pulse_timer_output === 1'b1 && c < 300)
      begin
        c++;
        @(posedge pclk);
      end
      chk(32'(n >= 1 && n <= 56), 32'h1);
      chk(32'(c >= 49 && c <= 101), 32'h1);
      if (n >= 300 || c >= 300)
      begin
        num_errors++;
        tally_and_finish();
      end
    end
    $display("test timer done");
    go(1'b1, 8'h04, 32'h2, 1'b0);
    for (i = 0; i < 2; i++)
    begin
      go(1'b1, 8'h44, 32'(i), 1'b0);
      // A pulse launched at the mode write edge is let pass before counting.
      cyc(2);
      c = 0;
      repeat (1000)
      begin
        c += free_run_trigger;
        @(posedge pclk);
      end
      chk(32'(i ? c == 0 : c >= 9 && c <= 11), 32'h1);
    end
    $display("test free run done");
    go(1'b1, 8'h20, 32'h1, 1'b0);
    go(1'b1, 8'h24, 32'hA, 1'b0);
    for (n = 0; n < 4; n++)
    begin
      go(1'b1, 8'h28, 32'(n / 2), 1'b0);
      go(1'b1, 8'h2C, 32'(n % 2), 1'b0);
      cyc(2);
      chk({30'h0, line_oe_n, line_out}, 32'((n / 2) ^ (n % 2)));
    end
    go(1'b1, 8'h24, 32'h0, 1'b0);
    cyc(2);
    chk({30'h0, line_oe_n, line_out}, 32'h2);
    // Frame, exposure and timer sources in turn, with the inverter still on.
    for (n = 0; n < 300; n++)
    begin
      if (n % 100 == 0)
        go(1'b1, 8'h24, 32'(src[n < 200 ? n / 100 + 1 : 4]), 1'b0);
      i = n < 100 ? frame_active : n < 200 ? exposure_active : pulse_timer_output;
      {frame_active, exposure_active} <= 2'($urandom);
      @(posedge pclk);
      chk({30'h0, line_oe_n, line_out}, 32'(i ^ 1));
    end
    $display("test line done");
    tally_and_finish();
  end
endmodule // tb_camera_cfg
`default_nettype wire

// File: verilog/camera_cfg.sv
// APB slave that holds the camera output, flat field, control line and pulse timer settings.
`include "camera_cfg_consts.svh"
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Pixel depth 8 or 10, readable back
// - Free-run trigger at set rate, mode off
// - Tap codes 2,4,8,10 select output geometry
// - Clock selector 0 fast, 1 slow
// - Defect correction enable bit
// - Horizontal flip enable bit
// - Generate command pulses flat field generator
// - Flat field location selector 0 to 3
// - Save command stores data at selector
// - Load command copies stored data to working
// - Line mode 0 input, 1 output
// - Line source selects driven signal
// - Inverter bit flips line output polarity
// - User output bit sets line level
// - Timer trigger source off, frame, exposure
// - Timer pulse lasts programmed microseconds
// - Programmed delay before timer pulse
// - Trigger qualified by edge or level
module camera_cfg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_active,
  input wire logic exposure_active,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n,
  output logic ten_bit_depth,
  output logic [3:0] tap_count,
  output logic slow_pixel_clock,
  output logic defect_correct_en,
  output logic flip_en,
  output logic ffc_generate,
  output logic ffc_save,
  output logic ffc_load,
  output logic [1:0] ffc_location,
  output logic free_run_trigger,
  output logic pulse_timer_output
);
  import camera_cfg_pkg::*;
  logic [3:0] depth_reg, tap_reg;
  logic [1:0] ffc_sel_reg, tmr_act_reg;
  logic clk_sel_reg, defect_reg, flip_reg, line_mode_reg, line_inv_reg, user_out_reg, trig_mode_reg;
  us_count_t frame_period_reg, tmr_dur_reg, tmr_dly_reg, tmr_cnt_reg, frame_cnt_reg;
  src_code_t line_src_reg, tmr_src_reg;
  timer_state_t tmr_state_reg;
  logic [5:0] us_cnt_reg;
  logic us_tick, trig_sig, trig_prev_reg, trig_hit, wr_en, line_level;
  logic [31:0] rd_value;

  // Returns one when the address is a register in its allowed direction (command write-only, status read-only) and, for a write, the value lies in its legal set.
  function automatic logic access_ok(input logic [7:0] a, input logic [31:0] d, input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (a)
      `OFS_DEPTH: ok = !wr || d == `DEPTH_8 || d == `DEPTH_10;
      `OFS_TAP: ok = !wr || d == `TAP_2 || d == `TAP_4 || d == `TAP_8 || d == `TAP_10;
      `OFS_FRAME_PERIOD, `OFS_TMR_DUR: ok = !wr || (d >= `TIME_US_MIN_DUR && d <= `TIME_US_MAX);
      `OFS_TMR_DLY: ok = !wr || d <= `TIME_US_MAX;
      `OFS_CLK_SEL, `OFS_DEFECT, `OFS_FLIP, `OFS_LINE_MODE, `OFS_LINE_INV, `OFS_USER_OUT,
      `OFS_TRIG_MODE: ok = !wr || d <= `BIT_MAX;
      `OFS_FFC_SEL: ok = !wr || d <= `FFC_SEL_MAX;
      `OFS_TMR_ACT: ok = !wr || d <= `ACT_MAX;
      `OFS_LINE_SRC: ok = !wr || d == `SRC_OFF || d == `SRC_FRAME || d == `SRC_EXPO || d == `SRC_USER ||
                          d == `SRC_TIMER;
      `OFS_TMR_SRC: ok = !wr || d == `SRC_OFF || d == `SRC_FRAME || d == `SRC_EXPO;
      `OFS_FFC_CMD: ok = wr;
      `OFS_STATUS: ok = !wr;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction
  // A write commits at the access edge only when it was accepted.
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (paddr)
      `OFS_DEPTH: rd_value = {28'h000_0000, depth_reg};
      `OFS_FRAME_PERIOD: rd_value = {6'h00, frame_period_reg};
      `OFS_TAP: rd_value = {28'h000_0000, tap_reg};
      `OFS_CLK_SEL: rd_value = {31'h0000_0000, clk_sel_reg};
      `OFS_DEFECT: rd_value = {31'h0000_0000, defect_reg};
      `OFS_FLIP: rd_value = {31'h0000_0000, flip_reg};
      `OFS_FFC_SEL: rd_value = {30'h0000_0000, ffc_sel_reg};
      `OFS_LINE_MODE: rd_value = {31'h0000_0000, line_mode_reg};
      `OFS_LINE_SRC: rd_value = {27'h000_0000, line_src_reg};
      `OFS_LINE_INV: rd_value = {31'h0000_0000, line_inv_reg};
      `OFS_USER_OUT: rd_value = {31'h0000_0000, user_out_reg};
      `OFS_TMR_SRC: rd_value = {27'h000_0000, tmr_src_reg};
      `OFS_TMR_DUR: rd_value = {6'h00, tmr_dur_reg};
      `OFS_TMR_DLY: rd_value = {6'h00, tmr_dly_reg};
      `OFS_TMR_ACT: rd_value = {30'h0000_0000, tmr_act_reg};
      `OFS_TRIG_MODE: rd_value = {31'h0000_0000, trig_mode_reg};
      `OFS_STATUS: rd_value = {26'h000_0000, tmr_state_reg, line_in, exposure_active, frame_active};
      default: rd_value = 32'h0000_0000;
    endcase
  end
  // The answer is prepared in the setup cycle so that every bus output comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !access_ok(paddr, pwdata, pwrite);
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      depth_reg <= `RST_DEPTH;
      frame_period_reg <= `RST_FRAME_PERIOD;
      tap_reg <= `RST_TAP;
      clk_sel_reg <= 1'b0;
      defect_reg <= 1'b0;
      flip_reg <= 1'b0;
      ffc_sel_reg <= 2'h0;
      line_mode_reg <= 1'b0;
      line_src_reg <= 5'h00;
      line_inv_reg <= 1'b0;
      user_out_reg <= 1'b0;
      tmr_src_reg <= 5'h00;
      tmr_dur_reg <= `RST_TMR_DUR;
      tmr_dly_reg <= 26'h000_0000;
      tmr_act_reg <= `ACT_RISE;
      trig_mode_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `OFS_DEPTH: depth_reg <= pwdata[3:0];
        `OFS_FRAME_PERIOD: frame_period_reg <= pwdata[25:0];
        `OFS_TAP: tap_reg <= pwdata[3:0];
        `OFS_CLK_SEL: clk_sel_reg <= pwdata[0];
        `OFS_DEFECT: defect_reg <= pwdata[0];
        `OFS_FLIP: flip_reg <= pwdata[0];
        `OFS_FFC_SEL: ffc_sel_reg <= pwdata[1:0];
        `OFS_LINE_MODE: line_mode_reg <= pwdata[0];
        `OFS_LINE_SRC: line_src_reg <= pwdata[4:0];
        `OFS_LINE_INV: line_inv_reg <= pwdata[0];
        `OFS_USER_OUT: user_out_reg <= pwdata[0];
        `OFS_TMR_SRC: tmr_src_reg <= pwdata[4:0];
        `OFS_TMR_DUR: tmr_dur_reg <= pwdata[25:0];
        `OFS_TMR_DLY: tmr_dly_reg <= pwdata[25:0];
        `OFS_TMR_ACT: tmr_act_reg <= pwdata[1:0];
        `OFS_TRIG_MODE: trig_mode_reg <= pwdata[0];
        default: ;
      endcase
    end
  end
  // Output settings follow their registers one cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ten_bit_depth <= 1'b0;
      tap_count <= 4'h0;
      slow_pixel_clock <= 1'b0;
      defect_correct_en <= 1'b0;
      flip_en <= 1'b0;
      ffc_location <= 2'h0;
    end
    else
    begin
      ten_bit_depth <= depth_reg == `DEPTH_10;
      tap_count <= tap_reg;
      slow_pixel_clock <= clk_sel_reg;
      defect_correct_en <= defect_reg;
      flip_en <= flip_reg;
      ffc_location <= ffc_sel_reg;
    end
  end
  // Flat field commands are one-cycle pulses from a write to the command register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ffc_generate <= 1'b0;
      ffc_save <= 1'b0;
      ffc_load <= 1'b0;
    end
    else
    begin
      ffc_generate <= wr_en && paddr == `OFS_FFC_CMD && pwdata[`FFC_GEN_BIT];
      ffc_save <= wr_en && paddr == `OFS_FFC_CMD && pwdata[`FFC_SAVE_BIT];
      ffc_load <= wr_en && paddr == `OFS_FFC_CMD && pwdata[`FFC_LOAD_BIT];
    end
  end
  // Microsecond prescaler shared by the frame rate and timer counters.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      us_cnt_reg <= 6'h00;
    else if (us_cnt_reg == `US_CNT_LAST)
      us_cnt_reg <= 6'h00;
    else
      us_cnt_reg <= us_cnt_reg + 6'h01;
  end
  assign us_tick = us_cnt_reg == `US_CNT_LAST;
  // The free-run counter is held at zero while trigger mode is on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_cnt_reg <= 26'h000_0000;
      free_run_trigger <= 1'b0;
    end
    else if (trig_mode_reg)
    begin
      frame_cnt_reg <= 26'h000_0000;
      free_run_trigger <= 1'b0;
    end
    else if (us_tick && frame_cnt_reg + 26'h000_0001 >= frame_period_reg)
    begin
      frame_cnt_reg <= 26'h000_0000;
      free_run_trigger <= 1'b1;
    end
    else
    begin
      frame_cnt_reg <= us_tick ? frame_cnt_reg + 26'h000_0001 : frame_cnt_reg;
      free_run_trigger <= 1'b0;
    end
  end
  always_comb
  begin
    trig_sig = 1'b0;
    if (tmr_src_reg == 5'(`SRC_FRAME))
      trig_sig = frame_active;
    else if (tmr_src_reg == 5'(`SRC_EXPO))
      trig_sig = exposure_active;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig_sig;
  end
  always_comb
  begin
    trig_hit = 1'b0;
    unique case (tmr_act_reg)
      `ACT_FALL: trig_hit = trig_prev_reg && !trig_sig;
      `ACT_RISE: trig_hit = !trig_prev_reg && trig_sig;
      `ACT_LOW: trig_hit = !trig_sig;
      `ACT_HIGH: trig_hit = trig_sig;
    endcase
    if (tmr_src_reg == 5'(`SRC_OFF))
      trig_hit = 1'b0;
  end
  // Triggers are ignored while a delay or pulse is in progress.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmr_state_reg <= TMR_IDLE;
      tmr_cnt_reg <= 26'h000_0000;
      pulse_timer_output <= 1'b0;
    end
    else
    begin
      unique case (tmr_state_reg)
        TMR_IDLE:
        begin
          tmr_cnt_reg <= 26'h000_0000;
          if (trig_hit && tmr_dly_reg == 26'h000_0000)
          begin
            tmr_state_reg <= TMR_PULSE;
            pulse_timer_output <= 1'b1;
          end
          else if (trig_hit)
            tmr_state_reg <= TMR_DELAY;
        end
        TMR_DELAY:
        begin
          if (us_tick && tmr_cnt_reg + 26'h000_0001 >= tmr_dly_reg)
          begin
            tmr_state_reg <= TMR_PULSE;
            tmr_cnt_reg <= 26'h000_0000;
            pulse_timer_output <= 1'b1;
          end
          else if (us_tick)
            tmr_cnt_reg <= tmr_cnt_reg + 26'h000_0001;
        end
        TMR_PULSE:
        begin
          if (us_tick && tmr_cnt_reg + 26'h000_0001 >= tmr_dur_reg)
          begin
            tmr_state_reg <= TMR_IDLE;
            tmr_cnt_reg <= 26'h000_0000;
            pulse_timer_output <= 1'b0;
          end
          else if (us_tick)
            tmr_cnt_reg <= tmr_cnt_reg + 26'h000_0001;
        end
        default:
        begin
          tmr_state_reg <= TMR_IDLE;
          tmr_cnt_reg <= 26'h000_0000;
          pulse_timer_output <= 1'b0;
        end
      endcase
    end
  end
  always_comb
  begin
    line_level = 1'b0;
    if (line_src_reg == 5'(`SRC_FRAME))
      line_level = frame_active;
    else if (line_src_reg == 5'(`SRC_EXPO))
      line_level = exposure_active;
    else if (line_src_reg == 5'(`SRC_USER))
      line_level = user_out_reg;
    else if (line_src_reg == 5'(`SRC_TIMER))
      line_level = pulse_timer_output;
  end
  // The line is driven only in output mode with a source selected.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_out <= 1'b0;
      line_oe_n <= 1'b1;
    end
    else
    begin
      line_oe_n <= !(line_mode_reg && line_src_reg != 5'(`SRC_OFF));
      line_out <= line_src_reg == 5'(`SRC_OFF) ? 1'b0 : line_level ^ line_inv_reg;
    end
  end
endmodule // camera_cfg
`default_nettype wire

// File: verilog/camera_cfg_consts.svh
// Register offsets, field codes, reset values and timing constants of the camera configuration block.
`ifndef CAMERA_CFG_CONSTS_SVH
`define CAMERA_CFG_CONSTS_SVH
`define OFS_DEPTH 8'h00
`define OFS_FRAME_PERIOD 8'h04
`define OFS_TAP 8'h08
`define OFS_CLK_SEL 8'h0C
`define OFS_DEFECT 8'h10
`define OFS_FLIP 8'h14
`define OFS_FFC_SEL 8'h18
`define OFS_FFC_CMD 8'h1C
`define OFS_LINE_MODE 8'h20
`define OFS_LINE_SRC 8'h24
`define OFS_LINE_INV 8'h28
`define OFS_USER_OUT 8'h2C
`define OFS_TMR_SRC 8'h30
`define OFS_TMR_DUR 8'h34
`define OFS_TMR_DLY 8'h38
`define OFS_TMR_ACT 8'h3C
`define OFS_STATUS 8'h40
`define OFS_TRIG_MODE 8'h44
`define DEPTH_8 32'h0000_0008
`define DEPTH_10 32'h0000_000A
`define TAP_2 32'h0000_0002
`define TAP_4 32'h0000_0004
`define TAP_8 32'h0000_0008
`define TAP_10 32'h0000_000A
`define SRC_OFF 32'h0000_0000
`define SRC_FRAME 32'h0000_0004
`define SRC_EXPO 32'h0000_0006
`define SRC_USER 32'h0000_000A
`define SRC_TIMER 32'h0000_0012
`define ACT_FALL 2'h0
`define ACT_RISE 2'h1
`define ACT_LOW 2'h2
`define ACT_HIGH 2'h3
`define BIT_MAX 32'h0000_0001
`define FFC_SEL_MAX 32'h0000_0003
`define ACT_MAX 32'h0000_0003
`define TIME_US_MAX 32'h0393_8700
`define TIME_US_MIN_DUR 32'h0000_0001
`define FFC_GEN_BIT 0
`define FFC_SAVE_BIT 1
`define FFC_LOAD_BIT 2
`define RST_DEPTH 4'h8
`define RST_TAP 4'h2
`define RST_FRAME_PERIOD 26'h000_03E8
`define RST_TMR_DUR 26'h000_0001
`define CLK_MHZ 50
`define US_CYCLES (1 * `CLK_MHZ)
`define US_CNT_LAST 6'(`US_CYCLES - 1)
`endif

// File: verilog/camera_cfg_pkg.sv
// Types shared by the camera configuration block.
package camera_cfg_pkg;
  typedef enum logic [2:0] {
    TMR_IDLE = 3'b001,
    TMR_DELAY = 3'b010,
    TMR_PULSE = 3'b100
  } timer_state_t;
  typedef logic [25:0] us_count_t;
  typedef logic [4:0] src_code_t;
endpackage
